// ### crr_pkg.sv
// package for the capacitance result and status register bank
package crr_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned INT_BITS = 3;
  localparam int unsigned FRAC_BITS = 21;
  localparam int unsigned NUM_CAP = 7;
  localparam int unsigned NUM_PORTS = 8;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CAP_RATIO_1 = 4'h1;
  localparam logic [3:0] IDX_CAP_RATIO_7 = 4'h7;
  localparam logic [3:0] IDX_MEASURE_STATUS = 4'h8;
  localparam logic [3:0] IDX_EXT_SENSOR_RES_RATIO = 4'hD;
  localparam logic [3:0] IDX_SECOND_SENSOR_RES_RATIO = 4'hE;
  localparam logic [3:0] IDX_CONTROL = 4'hF;
  // status bit positions
  localparam int unsigned ST_COMM_DURING_MEASURE = 23;
  localparam int unsigned ST_TEMP_END = 22;
  localparam int unsigned ST_RUN_ENABLE = 20;
  localparam int unsigned ST_ANY_ERROR = 16;
  localparam int unsigned ST_CAP_CONVERTER_ERROR = 13;
  localparam int unsigned ST_PORT_ERR_HI = 12;
  localparam int unsigned ST_PORT_ERR_LO = 5;
  localparam int unsigned ST_RES_ERR = 3;
  // control register bits
  localparam int unsigned CTL_RUN_ENABLE = 0;
  localparam int unsigned CTL_IRQ_TO_GP = 1;
  localparam int unsigned CTL_HALT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] RESULT_RESET = 24'h000000;

  typedef struct packed {
    logic cap_converter_error;
    logic [NUM_PORTS-1:0] cap_port_error_flags;
    logic res_converter_error;
    logic temp_end;
    logic measure_active;
    logic host_access;
  } crr_front_t;

  typedef struct packed {
    logic wr_en;
    logic [3:0] wr_idx;
    logic [DATA_W-1:0] wr_data;
    logic data_ready;
  } crr_dsp_wr_t;
endpackage

// ### crr_regs.sv
// result and status register bank with axi4-lite slave and dsp clock gating
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - addresses 1 to 7 hold 24-bit capacitance ratios, unsigned 3.21 format
// - status sits at address 8 with fixed bit layout, firmware independent
// - status driven by hardware only, unaffected by dsp running or idle
// - bit 23 set when host access happens during a measurement
// - bit 22 signals temperature measurement completed
// - bit 20 mirrors the run-enable bit of the control register
// - bit 16 is the or of all error flags
// - bit 13 flags capacitance converter overflow or error
// - bits 12 to 5 flag errors per capacitance port
// - bit 3 flags resistance converter overflow or error
// - address 13 holds external sensor to reference ratio, 3.21 format
// - address 14 holds second sensor to reference ratio, 3.21 format
// - result registers other than status are written only by the dsp
// - dsp works on 48-bit words beside a 48 by 48 working memory
// - a firmware halt command stops the dsp clock
// - halted dsp restarts on gpio event or end of measurement run
// - dsp raises an interrupt line when new results are ready
// - standard firmware writes compensated ratios, first-order linearization only
// - routing bit set sends interrupt out on general-purpose pin 2
////////////////////////////////////////////////////////////////////////////////
module crr_regs
  import crr_pkg::*;
#(
  parameter int unsigned DSP_W = 48,
  parameter int unsigned DSP_MEM_DEPTH = 48
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // front end status
  input wire crr_front_t front,
  // dsp result writes and wake events
  input wire crr_dsp_wr_t dsp_wr,
  input wire logic [DSP_W-1:0] dsp_mem_wdata,
  input wire logic [$clog2(DSP_MEM_DEPTH)-1:0] dsp_mem_addr,
  input wire logic dsp_mem_we,
  input wire logic dsp_halt_cmd,
  input wire logic gpio_wake,
  input wire logic run_end,
  // outputs
  output logic dsp_clk_en,
  output logic [DSP_W-1:0] dsp_mem_rdata,
  output logic irq_pin_n,
  output logic gp_pin_2,
  output logic run_enable
);

  typedef struct packed {
    logic [NUM_CAP-1:0][DATA_W-1:0] cap_ratio;
    logic [DATA_W-1:0] ext_sensor_res_ratio;
    logic [DATA_W-1:0] second_sensor_res_ratio;
    logic comm_during_measure_flag;
    logic temp_end_flag;
    logic run_en;
    logic irq_to_gp_pin_select;
    logic dsp_running;
    logic data_ready;
    logic aw_held;
    logic [3:0] aw_idx;
    logic aw_ok;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crr_state_t;

  crr_state_t st_reg;
  crr_state_t st_next;
  logic [DSP_W-1:0] dsp_mem [DSP_MEM_DEPTH];
  logic [DSP_W-1:0] mem_rd_reg;
  logic [DATA_W-1:0] status_word;
  logic any_error;

  // word index from a byte address; low bits must be zero
  function automatic logic [3:0] word_idx(input logic [5:0] a);
    return a[5:2];
  endfunction

  function automatic logic aligned(input logic [5:0] a);
    return a[1:0] == 2'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combined error
  assign any_error = front.cap_converter_error | (|front.cap_port_error_flags)
    | front.res_converter_error;

  // status built from hardware flags only, never from dsp state
  always_comb begin
    status_word = '0;
    status_word[ST_COMM_DURING_MEASURE] = st_reg.comm_during_measure_flag;
    status_word[ST_TEMP_END] = st_reg.temp_end_flag;
    status_word[ST_RUN_ENABLE] = st_reg.run_en;
    status_word[ST_ANY_ERROR] = any_error;
    status_word[ST_CAP_CONVERTER_ERROR] = front.cap_converter_error;
    status_word[ST_PORT_ERR_HI:ST_PORT_ERR_LO] = front.cap_port_error_flags;
    status_word[ST_RES_ERR] = front.res_converter_error;
  end

  function automatic logic [31:0] read_word(input crr_state_t s, input logic [3:0] idx,
                                            input logic [DATA_W-1:0] stw);
    logic [31:0] v;
    v = '0;
    if (idx >= IDX_CAP_RATIO_1 && idx <= IDX_CAP_RATIO_7) begin
      v[DATA_W-1:0] = s.cap_ratio[idx - IDX_CAP_RATIO_1];
    end else if (idx == IDX_MEASURE_STATUS) begin
      v[DATA_W-1:0] = stw;
    end else if (idx == IDX_EXT_SENSOR_RES_RATIO) begin
      v[DATA_W-1:0] = s.ext_sensor_res_ratio;
    end else if (idx == IDX_SECOND_SENSOR_RES_RATIO) begin
      v[DATA_W-1:0] = s.second_sensor_res_ratio;
    end else if (idx == IDX_CONTROL) begin
      v[CTL_RUN_ENABLE] = s.run_en;
      v[CTL_IRQ_TO_GP] = s.irq_to_gp_pin_select;
      v[CTL_HALT] = ~s.dsp_running;
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [3:0] idx);
    return (idx >= IDX_CAP_RATIO_1 && idx <= IDX_MEASURE_STATUS)
      || idx == IDX_EXT_SENSOR_RES_RATIO || idx == IDX_SECOND_SENSOR_RES_RATIO
      || idx == IDX_CONTROL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic host_ev;
    logic do_wr;
    host_ev = 1'b0;
    do_wr = 1'b0;
    st_next = st_reg;
    // address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx = word_idx(s_axi_awaddr);
      st_next.aw_ok = aligned(s_axi_awaddr);
      host_ev = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      do_wr = 1'b1;
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      // only the control word is writable; results are read-only to the host
      st_next.bresp = (st_reg.aw_ok && st_reg.aw_idx == IDX_CONTROL) ? RESP_OKAY : RESP_SLVERR;
    end
    if (do_wr && st_reg.aw_ok && st_reg.aw_idx == IDX_CONTROL && st_reg.w_strb[0]) begin
      st_next.run_en = st_reg.w_data[CTL_RUN_ENABLE];
      st_next.irq_to_gp_pin_select = st_reg.w_data[CTL_IRQ_TO_GP];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      host_ev = 1'b1;
      st_next.rvalid = 1'b1;
      st_next.rdata = read_word(st_reg, word_idx(s_axi_araddr), status_word);
      st_next.rresp = (aligned(s_axi_araddr) && mapped(word_idx(s_axi_araddr)))
        ? RESP_OKAY : RESP_SLVERR;
      // temperature end flag cleared by reading status
      if (word_idx(s_axi_araddr) == IDX_MEASURE_STATUS) begin
        st_next.temp_end_flag = 1'b0;
        st_next.comm_during_measure_flag = 1'b0;
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // set wins over the clear on status read
    if ((host_ev || front.host_access) && front.measure_active) begin
      st_next.comm_during_measure_flag = 1'b1;
    end
    if (front.temp_end) begin
      st_next.temp_end_flag = 1'b1;
    end
    // compensated ratios from firmware arrive only through these writes
    // only the dsp writes results; others hold their value
    if (dsp_wr.wr_en) begin
      if (dsp_wr.wr_idx >= IDX_CAP_RATIO_1 && dsp_wr.wr_idx <= IDX_CAP_RATIO_7) begin
        st_next.cap_ratio[dsp_wr.wr_idx - IDX_CAP_RATIO_1] = dsp_wr.wr_data;
      end else if (dsp_wr.wr_idx == IDX_EXT_SENSOR_RES_RATIO) begin
        st_next.ext_sensor_res_ratio = dsp_wr.wr_data;
      end else if (dsp_wr.wr_idx == IDX_SECOND_SENSOR_RES_RATIO) begin
        st_next.second_sensor_res_ratio = dsp_wr.wr_data;
      end
    end
    // data ready latched until the next result write
    if (dsp_wr.data_ready) begin
      st_next.data_ready = 1'b1;
    end else if (dsp_wr.wr_en) begin
      st_next.data_ready = 1'b0;
    end
    // wake wins over halt; halt stops the clock
    if (gpio_wake || run_end) begin
      st_next.dsp_running = 1'b1;
    end else if (dsp_halt_cmd && st_reg.dsp_running) begin
      st_next.dsp_running = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.dsp_running <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 48-bit working memory, only written while the dsp clock runs; read every cycle
  always_ff @(posedge aclk) begin
    if (dsp_mem_we && st_reg.dsp_running) begin
      dsp_mem[dsp_mem_addr] <= dsp_mem_wdata;
    end
    mem_rd_reg <= dsp_mem[dsp_mem_addr];
  end

  assign dsp_mem_rdata = mem_rd_reg;
  assign dsp_clk_en = st_reg.dsp_running;
  // active-low interrupt; optionally on gp pin 2
  assign irq_pin_n = ~st_reg.data_ready;
  assign gp_pin_2 = st_reg.irq_to_gp_pin_select & st_reg.data_ready;
  assign run_enable = st_reg.run_en;

  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  ////////////////////////////////////////////////////////////////////////////
  run_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(run_enable) |-> $rose(s_axi_bvalid) && status_word[ST_RUN_ENABLE] == run_enable)
    else $error("status run bit differs from control");
  any_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_word[ST_ANY_ERROR] == (|{status_word[ST_CAP_CONVERTER_ERROR],
      status_word[ST_PORT_ERR_HI:ST_PORT_ERR_LO], status_word[ST_RES_ERR]}))
    else $error("combined error flag wrong");
  cap_converter_error_a: assert property (@(posedge aclk) disable iff (!aresetn)
    front.cap_converter_error |-> status_word[ST_CAP_CONVERTER_ERROR] && status_word[ST_ANY_ERROR])
    else $error("cap converter error not shown");
  port_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_word[ST_PORT_ERR_HI:ST_PORT_ERR_LO] == front.cap_port_error_flags)
    else $error("port error flags wrong");
  res_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    front.res_converter_error |-> status_word[ST_RES_ERR])
    else $error("res converter error not shown");
  comm_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && front.measure_active) |=> st_reg.comm_during_measure_flag)
    else $error("comm during measure not flagged");
  temp_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    front.temp_end |=> status_word[ST_TEMP_END])
    else $error("temperature end not flagged");
  halt_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (gpio_wake || run_end) |=> dsp_clk_en)
    else $error("dsp not woken");
  halt_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (dsp_halt_cmd && !gpio_wake && !run_end) |=> !dsp_clk_en)
    else $error("dsp clock not halted");
  result_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !dsp_wr.wr_en |=> $stable(st_reg.ext_sensor_res_ratio) && $stable(st_reg.cap_ratio))
    else $error("result changed without dsp write");
  irq_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    gp_pin_2 |-> !irq_pin_n && st_reg.irq_to_gp_pin_select)
    else $error("gp pin interrupt misrouted");
  rdata_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rdata[31:DATA_W] == '0)
    else $error("read data upper bits not zero");
  status_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && aligned(s_axi_araddr)
      && word_idx(s_axi_araddr) == IDX_MEASURE_STATUS)
      |=> s_axi_rdata[DATA_W-1:0] == $past(status_word) && s_axi_rresp == RESP_OKAY)
    else $error("status read wrong");
  ext_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && aligned(s_axi_araddr)
      && word_idx(s_axi_araddr) == IDX_EXT_SENSOR_RES_RATIO)
      |=> s_axi_rdata[DATA_W-1:0] == $past(st_reg.ext_sensor_res_ratio))
    else $error("external ratio read wrong");
  second_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && aligned(s_axi_araddr)
      && word_idx(s_axi_araddr) == IDX_SECOND_SENSOR_RES_RATIO)
      |=> s_axi_rdata[DATA_W-1:0] == $past(st_reg.second_sensor_res_ratio))
    else $error("second ratio read wrong");
  second_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !dsp_wr.wr_en |=> $stable(st_reg.second_sensor_res_ratio))
    else $error("second ratio changed without dsp write");
  host_refused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(s_axi_bvalid) && st_reg.aw_idx != IDX_CONTROL) |-> s_axi_bresp == RESP_SLVERR)
    else $error("host write to result accepted");
  comm_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.comm_during_measure_flag && !(s_axi_arvalid && s_axi_arready))
      |=> st_reg.comm_during_measure_flag)
    else $error("comm flag lost");
  temp_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.temp_end_flag && !(s_axi_arvalid && s_axi_arready)) |=> st_reg.temp_end_flag)
    else $error("temperature end flag lost");
  irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dsp_wr.data_ready |=> !irq_pin_n)
    else $error("interrupt not raised");
  irq_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!irq_pin_n && !dsp_wr.wr_en) |=> !irq_pin_n)
    else $error("interrupt dropped early");
  gp_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.irq_to_gp_pin_select && !irq_pin_n) |-> gp_pin_2)
    else $error("routed interrupt missing");
  halt_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!dsp_clk_en && !gpio_wake && !run_end) |=> !dsp_clk_en)
    else $error("dsp clock restarted without wake");
  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  status_live_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_word[ST_RUN_ENABLE] == run_enable
      && status_word[ST_RES_ERR] == front.res_converter_error)
    else $error("status not hardware driven");
endmodule

// ### crr_host_model.sv
// axi4-lite host model, one read and one write at most under way
`timescale 1ns/10ps
module crr_host_model
  import crr_pkg::*;
(
  // clock
  input wire logic aclk,
  // write side
  output logic [5:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read side
  output logic [5:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  localparam int LIMIT = 64;
  function automatic logic [31:0] known_bits(input logic [31:0] d);
    return d & 32'h00D13FE8;
  endfunction
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 48'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d,
                           output logic [1:0] resp, output logic ok);
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    ok = 1'b0;
    resp = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < LIMIT && !ok; i++) begin
      // sampled at the taking edge, before the slave's registers update
      @(posedge aclk);
      aw_hit = s_axi_awvalid & s_axi_awready;
      w_hit = s_axi_wvalid & s_axi_wready;
      b_hit = s_axi_bvalid & s_axi_bready;
      resp = s_axi_bresp;
      // released lines show the inverse, never a stale value
      if (aw_hit) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_hit) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (b_hit) begin
        s_axi_bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
  task automatic axi_read(input logic [5:0] a, output logic [31:0] d,
                          output logic [1:0] resp, output logic ok);
    logic ar_hit;
    logic r_hit;
    ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < LIMIT && !ok; i++) begin
      @(posedge aclk);
      ar_hit = s_axi_arvalid & s_axi_arready;
      r_hit = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      if (ar_hit) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (r_hit) begin
        s_axi_rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// ### tb_cap_result_status_regs.sv
// self-checking bench for the result and status register bank
`timescale 1ns/10ps
module tb_cap_result_status_regs;
  import crr_pkg::*;
  localparam logic [5:0] A_STAT = {IDX_MEASURE_STATUS, 2'b00};
  localparam logic [5:0] A_CTL = {IDX_CONTROL, 2'b00};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, dsp_mem_we, dsp_clk_en, irq_pin_n, gp_pin_2, run_enable;
  logic [5:0] s_axi_awaddr, s_axi_araddr, dsp_mem_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [47:0] dsp_mem_wdata, dsp_mem_rdata;
  logic [2:0] ev;
  crr_front_t front;
  crr_dsp_wr_t dsp_wr;
  int err_count;
  int comparisons;
  crr_regs uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .front, .dsp_wr, .dsp_mem_wdata,
    .dsp_mem_addr, .dsp_mem_we, .dsp_halt_cmd(ev[2]), .gpio_wake(ev[1]), .run_end(ev[0]),
    .dsp_clk_en, .dsp_mem_rdata, .irq_pin_n, .gp_pin_2, .run_enable);
  crr_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang_check(input logic ok);
    if (ok !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic ok;
    host.axi_write(a, d, r, ok);
    hang_check(ok);
    check(48'(r), 48'(er));
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    logic ok;
    host.axi_read(a, d, r, ok);
    hang_check(ok);
    if (a == A_STAT) begin
      d = host.known_bits(d);
    end
    check(48'({r, d}), 48'({er, ed}));
  endtask
  task automatic dsp_put(input logic en, input logic [3:0] i, input logic [23:0] d,
                         input logic dr);
    @(posedge aclk);
    dsp_wr <= '{wr_en: en, wr_idx: i, wr_data: d, data_ready: dr};
    @(posedge aclk);
    dsp_wr <= '0;
    repeat (2) @(negedge aclk);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 3'h0;
    repeat (2) @(negedge aclk);
  endtask
  task automatic err_case(input logic c, input logic [7:0] p, input logic r,
                          input logic [31:0] e);
    @(posedge aclk);
    front.cap_converter_error <= c;
    front.cap_port_error_flags <= p;
    front.res_converter_error <= r;
    rd(A_STAT, e, RESP_OKAY);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // a hang anywhere ends the run as a failure
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    err_count = 0;
    comparisons = 0;
    aresetn = 1'b0;
    front = '0;
    dsp_wr = '0;
    {dsp_mem_wdata, dsp_mem_addr, dsp_mem_we, ev} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(48'({irq_pin_n, gp_pin_2, dsp_clk_en, run_enable}), 48'hA);
    rd(A_STAT, 32'h00000000, RESP_OKAY);
    for (int i = 1; i < 15; i++) begin
      if (i < 8 || i > 12) begin
        dsp_put(1'b1, 4'(i), {~4'(i), 20'h5A5A5}, 1'b0);
        rd({4'(i), 2'b00}, {8'h00, ~4'(i), 20'h5A5A5}, RESP_OKAY);
      end
    end
    wr(6'h04, 32'h00FFFFFF, RESP_SLVERR);
    rd(6'h04, 32'h00E5A5A5, RESP_OKAY);
    rd(6'h28, 32'h00000000, RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      dsp_mem_we <= 1'b1;
      dsp_mem_addr <= 6'(i * 47);
      dsp_mem_wdata <= {42'h2AAAAAAAAAA, 6'(i * 47)};
    end
    @(posedge aclk);
    dsp_mem_we <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      dsp_mem_addr <= 6'(i * 47);
      repeat (2) @(negedge aclk);
      check(dsp_mem_rdata, {42'h2AAAAAAAAAA, 6'(i * 47)});
    end
    wr(A_CTL, 32'h00000003, RESP_OKAY);
    check(48'(run_enable), 48'h1);
    rd(A_STAT, 32'h00100000, RESP_OKAY);
    dsp_put(1'b0, 4'h0, 24'h000000, 1'b1);
    check(48'({irq_pin_n, gp_pin_2}), 48'h1);
    wr(A_CTL, 32'h00000001, RESP_OKAY);
    repeat (2) @(negedge aclk);
    check(48'({irq_pin_n, gp_pin_2}), 48'h0);
    dsp_put(1'b1, 4'h2, 24'h123456, 1'b0);
    check(48'({irq_pin_n, gp_pin_2}), 48'h2);
    err_case(1'b0, 8'h80, 1'b0, 32'h00111000);
    err_case(1'b1, 8'h00, 1'b0, 32'h00112000);
    err_case(1'b0, 8'h00, 1'b1, 32'h00110008);
    err_case(1'b0, 8'h00, 1'b0, 32'h00100000);
    front.measure_active <= 1'b1;
    rd(6'h04, 32'h00E5A5A5, RESP_OKAY);
    front.measure_active <= 1'b0;
    rd(A_STAT, 32'h00900000, RESP_OKAY);
    rd(A_STAT, 32'h00100000, RESP_OKAY);
    @(posedge aclk);
    front.temp_end <= 1'b1;
    @(posedge aclk);
    front.temp_end <= 1'b0;
    rd(A_STAT, 32'h00500000, RESP_OKAY);
    rd(A_STAT, 32'h00100000, RESP_OKAY);
    pulse(3'h4);
    check(48'(dsp_clk_en), 48'h0);
    rd(A_CTL, 32'h00000005, RESP_OKAY);
    rd(A_STAT, 32'h00100000, RESP_OKAY);
    pulse(3'h2);
    check(48'(dsp_clk_en), 48'h1);
    pulse(3'h4);
    pulse(3'h1);
    check(48'(dsp_clk_en), 48'h1);
    tally_and_finish();
  end
endmodule
